// File: core/xtc_pkg.sv
// Constants shared by the external output and trigger control block.
package xtc_pkg;
  // Register numbers; byte address is four times the number
  localparam logic [9:0] IDX_MAIN_CTRL = 10'h000;
  localparam logic [9:0] IDX_CONFIG = 10'h001;
  localparam logic [9:0] IDX_TRIG_EVT = 10'h002;
  localparam logic [9:0] IDX_STATUS = 10'h004;
  localparam logic [9:0] IDX_EXT_EVT0 = 10'h068;
  localparam logic [9:0] IDX_IRQ_STATUS = 10'h0C0;
  localparam logic [9:0] IDX_IRQ_MASK = 10'h0C1;
  localparam logic [9:0] IDX_ID = 10'h3F2;
  // Management area bounds
  localparam logic [9:0] MGMT_LO0 = 10'h0C0;
  localparam logic [9:0] MGMT_HI0 = 10'h0C5;
  localparam logic [9:0] MGMT_LO1 = 10'h3C0;
  localparam logic [9:0] MGMT_HI1 = 10'h3FF;
  // Main control fields
  localparam int CTRL_PROG = 0;
  localparam int CTRL_TRIG_IND_EN = 2;
  localparam int CTRL_DBG_REQ_EN = 3;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  // Config field for output count
  localparam int CFG_EXT_LSB = 20;
  // Status fields
  localparam int ST_TRIGGERED = 0;
  localparam int ST_PROG_IDLE = 1;
  localparam int ST_ARMED = 3;
  // Event select layout: resource A, resource B, function
  localparam int EVT_W = 11;
  localparam int EVT_A_LSB = 0;
  localparam int EVT_B_LSB = 4;
  localparam int EVT_FN_LSB = 8;
  localparam int RES_IDX_W = 4;
  localparam int FN_W = 3;
  localparam logic [EVT_W-1:0] EVT_RESET = 11'h000;
  // Interrupt status bits
  localparam int IRQ_W = 2;
  localparam int IRQ_TRIG = 0;
  localparam int IRQ_IDLE = 1;
  // Identity word, value arbitrary
  localparam logic [31:0] ID_VALUE = 32'h0000_1234;
endpackage : xtc_pkg

// File: core/xtc_sync.sv
// Two-stage synchroniser for a bus of independent level inputs.
`timescale 1ns/1ps
module xtc_sync #(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  // Levels
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // First stage feeds only the second stage
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;
endmodule : xtc_sync

// File: core/xtc_evt_eval.sv
// Event logic: two selected resources combined by a chosen function.
`timescale 1ns/1ps
module xtc_evt_eval (
  // Resource levels and event selection
  input wire logic [15:0] res_in,
  input wire logic [xtc_pkg::EVT_W-1:0] sel_in,
  // Event result
  output logic hit_out
);
  logic a;
  logic b;
  logic [xtc_pkg::FN_W-1:0] fn;

  // Resource 15 is expected to be tied high for always/never events
  always_comb begin
    a = res_in[sel_in[xtc_pkg::EVT_A_LSB +: xtc_pkg::RES_IDX_W]];
    b = res_in[sel_in[xtc_pkg::EVT_B_LSB +: xtc_pkg::RES_IDX_W]];
    fn = sel_in[xtc_pkg::EVT_FN_LSB +: xtc_pkg::FN_W];
    case (fn)
      3'h0: hit_out = a;
      3'h1: hit_out = !a;
      3'h2: hit_out = a & b;
      3'h3: hit_out = !a & b;
      3'h4: hit_out = !a & !b;
      3'h5: hit_out = a | b;
      3'h6: hit_out = !a | b;
      3'h7: hit_out = !(a | b);
      default: hit_out = 1'b0;
    endcase
  end
endmodule : xtc_evt_eval

// File: core/xtc_top.sv
// External outputs, one-shot trigger and Wishbone register file.
`timescale 1ns/1ps
module xtc_top #(
  parameter int N_EXT_OUT = 4,
  parameter int N_RES = 16
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  // Wishbone classic slave
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [11:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  // Event resources from pins, asynchronous
  input wire logic [N_RES-1:0] event_res_in,
  // Trace path status, same clock
  input wire logic fifo_empty_in,
  // Trace control
  output logic trace_enable_out,
  output logic state_hold_out,
  output logic trig_packet_out,
  output logic trig_ind_out,
  output logic dbg_req_out,
  // External outputs
  output logic [3:0] ext_out_out,
  // Interrupt
  output logic irq_out
);
  // Elaboration checks
  if (N_EXT_OUT < 0 || N_EXT_OUT > 4) begin : g_chk_ext
    $error("N_EXT_OUT must be 0 to 4");
  end
  if (N_RES != 16) begin : g_chk_res
    $error("N_RES must be 16 for 4-bit resource selects");
  end

  localparam logic [2:0] EXT_COUNT = 3'(N_EXT_OUT);

  typedef logic [xtc_pkg::EVT_W-1:0] xtc_evt_t;

  typedef struct packed {
    logic [31:0] ctrl;
    xtc_evt_t trig_evt;
    xtc_evt_t [3:0] ext_evt;
    logic [xtc_pkg::IRQ_W-1:0] irq_st;
    logic [xtc_pkg::IRQ_W-1:0] irq_msk;
    logic armed;
    logic triggered;
    logic idle_prev;
    logic ack;
    logic [31:0] dat;
    logic [3:0] ext_out;
    logic trig_pkt;
    logic trig_ind;
    logic dbg_req;
    logic trace_en;
    logic hold;
    logic irq;
  } xtc_state_t;

  xtc_state_t st_q;
  xtc_state_t st_d;

  logic [N_RES-1:0] res_sync;
  logic trig_hit;
  logic [3:0] ext_hit;

  // Byte-lane merge used by every writable register but the interrupt status
  function automatic logic [31:0] apply_sel(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : apply_sel

  // Index of an external output event register, or 4 when none
  function automatic logic [2:0] ext_slot(input logic [9:0] idx);
    logic [2:0] r;
    r = 3'h4;
    for (int n = 0; n < N_EXT_OUT; n++) begin
      if (idx == xtc_pkg::IDX_EXT_EVT0 + 10'(n)) begin
        r = 3'(n);
      end
    end
    return r;
  endfunction : ext_slot

  // Management area membership, used to zero reads of unassigned management words
  function automatic logic is_mgmt(input logic [9:0] idx);
    return (idx >= xtc_pkg::MGMT_LO0 && idx <= xtc_pkg::MGMT_HI0) ||
           (idx >= xtc_pkg::MGMT_LO1 && idx <= xtc_pkg::MGMT_HI1);
  endfunction : is_mgmt

  // Pin resources cross into this clock before event logic sees them
  xtc_sync #(
    .W(N_RES)
  ) u_sync (
    .sys_clk_in(sys_clk_in),
    .rst_b_in(rst_b_in),
    .async_in(event_res_in),
    .sync_out(res_sync)
  );

  // Trigger uses the same event logic as the outputs
  xtc_evt_eval u_trig_eval (
    .res_in(res_sync),
    .sel_in(st_q.trig_evt),
    .hit_out(trig_hit)
  );

  // One evaluator per implemented output; the rest read low
  for (genvar g = 0; g < 4; g++) begin : g_ext
    if (g < N_EXT_OUT) begin : g_on
      xtc_evt_eval u_eval (
        .res_in(res_sync),
        .sel_in(st_q.ext_evt[g]),
        .hit_out(ext_hit[g])
      );
    end else begin : g_off
      assign ext_hit[g] = 1'b0;
    end
  end

  // Next-state logic for the whole block
  always_comb begin
    logic [9:0] idx;
    logic req;
    logic wr;
    logic prog;
    logic fire;
    logic idle;
    logic [2:0] slot;
    logic [xtc_pkg::IRQ_W-1:0] irq_set;
    logic [31:0] wmerge;
    logic [31:0] rd;
    wmerge = 32'h0000_0000;
    rd = 32'h0000_0000;
    idx = wb_adr_in[11:2];
    req = wb_cyc_in & wb_stb_in & !st_q.ack;
    wr = req & wb_we_in;
    slot = ext_slot(idx);
    st_d = st_q;

    prog = st_q.ctrl[xtc_pkg::CTRL_PROG];

    // Hold the run while programming; drain before calling it idle
    st_d.trace_en = !prog;
    st_d.hold = prog;
    idle = prog & fifo_empty_in;
    st_d.idle_prev = idle;

    // Outputs follow events, forced low while programming
    for (int n = 0; n < 4; n++) begin
      st_d.ext_out[n] = ext_hit[n] & !prog;
    end

    // One-shot trigger: armed while programming, fires once after release
    fire = !prog & st_q.armed & trig_hit;
    if (prog) begin
      st_d.armed = 1'b1;
      st_d.triggered = 1'b0;
    end else if (fire) begin
      st_d.armed = 1'b0;
      st_d.triggered = 1'b1;
    end
    st_d.trig_pkt = fire;
    st_d.trig_ind = fire & st_q.ctrl[xtc_pkg::CTRL_TRIG_IND_EN];
    st_d.dbg_req = fire & st_q.ctrl[xtc_pkg::CTRL_DBG_REQ_EN];

    // Wishbone: answer every request one cycle after it appears
    st_d.ack = req;
    if (wr) begin
      wmerge = 32'h0000_0000;
      case (idx)
        xtc_pkg::IDX_MAIN_CTRL: begin
          wmerge = apply_sel(st_q.ctrl, wb_dat_in, wb_sel_in);
          st_d.ctrl = wmerge;
        end
        xtc_pkg::IDX_TRIG_EVT: begin
          wmerge = apply_sel(32'(st_q.trig_evt), wb_dat_in, wb_sel_in);
          st_d.trig_evt = wmerge[xtc_pkg::EVT_W-1:0];
        end
        xtc_pkg::IDX_IRQ_MASK: begin
          wmerge = apply_sel(32'(st_q.irq_msk), wb_dat_in, wb_sel_in);
          st_d.irq_msk = wmerge[xtc_pkg::IRQ_W-1:0];
        end
        default: begin
          if (slot != 3'h4) begin
            wmerge = apply_sel(32'(st_q.ext_evt[slot[1:0]]), wb_dat_in,
                               wb_sel_in);
            st_d.ext_evt[slot[1:0]] = wmerge[xtc_pkg::EVT_W-1:0];
          end
          // Other numbers are read-only or reserved: write dropped; interrupt status is cleared below
        end
      endcase
    end

    // Sticky interrupt status; a new event beats a write-one clear
    irq_set = '0;
    irq_set[xtc_pkg::IRQ_TRIG] = fire;
    irq_set[xtc_pkg::IRQ_IDLE] = idle & !st_q.idle_prev;
    if (wr && idx == xtc_pkg::IDX_IRQ_STATUS && wb_sel_in[0]) begin
      st_d.irq_st = st_q.irq_st & ~wb_dat_in[xtc_pkg::IRQ_W-1:0];
    end
    st_d.irq_st = st_d.irq_st | irq_set;
    st_d.irq = |(st_d.irq_st & st_d.irq_msk);

    // Read mux; unassigned numbers read zero
    rd = 32'h0000_0000;
    case (idx)
      xtc_pkg::IDX_MAIN_CTRL: rd = st_q.ctrl;
      xtc_pkg::IDX_CONFIG: rd[xtc_pkg::CFG_EXT_LSB +: 3] = EXT_COUNT;
      xtc_pkg::IDX_TRIG_EVT: rd = 32'(st_q.trig_evt);
      xtc_pkg::IDX_STATUS: begin
        rd[xtc_pkg::ST_TRIGGERED] = st_q.triggered;
        rd[xtc_pkg::ST_PROG_IDLE] = idle;
        rd[xtc_pkg::ST_ARMED] = st_q.armed;
      end
      xtc_pkg::IDX_IRQ_STATUS: rd = 32'(st_q.irq_st);
      xtc_pkg::IDX_IRQ_MASK: rd = 32'(st_q.irq_msk);
      xtc_pkg::IDX_ID: rd = xtc_pkg::ID_VALUE;
      default: begin
        if (slot != 3'h4) begin
          rd = 32'(st_q.ext_evt[slot[1:0]]);
        end
      end
    endcase
    // Management words other than interrupt status, mask and identity read zero
    if (is_mgmt(idx) && idx != xtc_pkg::IDX_IRQ_STATUS &&
        idx != xtc_pkg::IDX_IRQ_MASK && idx != xtc_pkg::IDX_ID) begin
      rd = 32'h0000_0000;
    end
    // Single port serialises any concurrent masters upstream
    st_d.dat = req ? rd : 32'h0000_0000;
  end

  // State register; outputs leave straight from it
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_q <= '0;
      st_q.ctrl <= xtc_pkg::CTRL_RESET;
      st_q.trig_evt <= xtc_pkg::EVT_RESET;
      st_q.armed <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  assign wb_dat_out = st_q.dat;
  assign wb_ack_out = st_q.ack;
  assign trace_enable_out = st_q.trace_en;
  assign state_hold_out = st_q.hold;
  assign trig_packet_out = st_q.trig_pkt;
  assign trig_ind_out = st_q.trig_ind;
  assign dbg_req_out = st_q.dbg_req;
  assign ext_out_out = st_q.ext_out;
  assign irq_out = st_q.irq;
endmodule : xtc_top

// File: verif/xtc_trace_sink.sv
// Far-side model: trace buffer drain and trigger receiver.
`timescale 1ns/1ps
module xtc_trace_sink #(
  parameter int DRAIN = 6
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  // From the block
  input wire logic trace_enable_in,
  input wire logic trig_ind_in,
  // To the block and the bench
  output logic fifo_empty_out,
  output logic [7:0] trig_cnt_out
);
  int left;
  // Buffer holds data while trace runs; empties DRAIN+1 cycles after a stop
  always @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      left <= 0;
      fifo_empty_out <= 1'b1;
      trig_cnt_out <= 8'h00;
    end else begin
      if (trace_enable_in) begin
        left <= DRAIN;
        fifo_empty_out <= 1'b0;
      end else if (left > 0) begin
        left <= left - 1;
      end else begin
        fifo_empty_out <= 1'b1;
      end
      // Counts every trigger seen by the system side
      if (trig_ind_in) begin
        trig_cnt_out <= trig_cnt_out + 8'h01;
      end
    end
  end
endmodule : xtc_trace_sink

// File: verif/xtc_checker.sv
// Port checker for the external output and trigger block.
`timescale 1ns/1ps
module xtc_checker #(
  parameter int N_EXT_OUT = 4
) (
  // Watched ports
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_ack_out,
  input wire logic [31:0] wb_dat_out,
  input wire logic trace_enable_out,
  input wire logic state_hold_out,
  input wire logic trig_packet_out,
  input wire logic trig_ind_out,
  input wire logic dbg_req_out,
  input wire logic [3:0] ext_out_out
);
  logic fired_q;
  // Remembers a trigger until the next programming phase re-arms
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      fired_q <= 1'b0;
    end else if (state_hold_out) begin
      fired_q <= 1'b0;
    end else if (trig_packet_out) begin
      fired_q <= 1'b1;
    end
  end
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_b_in);
  a_ack_follows: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
    else $error("ack missing after request");
  a_ack_single: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack longer than one cycle");
  a_dat_idle: assert property (!wb_ack_out |-> wb_dat_out == 32'h0000_0000)
    else $error("read data outside ack");
  a_hold_low: assert property ($past(state_hold_out) && state_hold_out |-> ext_out_out == 4'h0)
    else $error("outputs not low while held");
  a_one_trig: assert property (trig_packet_out |-> !fired_q)
    else $error("second trigger in one run");
  a_no_trig_hold: assert property (state_hold_out |-> !trig_packet_out)
    else $error("trigger while held");
  a_ind_paired: assert property (trig_ind_out |-> trig_packet_out)
    else $error("indication without trigger");
  a_dbg_paired: assert property (dbg_req_out |-> trig_packet_out)
    else $error("debug request without trigger");
  a_enable_hold: assert property ($past(rst_b_in) |-> trace_enable_out == !state_hold_out)
    else $error("trace enable and hold disagree");
  a_ext_count: assert property ((ext_out_out >> N_EXT_OUT) == 4'h0)
    else $error("unimplemented output driven");
  c_trig: cover property (trig_packet_out);
  c_ind: cover property (trig_ind_out && dbg_req_out);
  c_ext: cover property (ext_out_out == 4'hF);
endmodule : xtc_checker
bind xtc_top xtc_checker #(.N_EXT_OUT(N_EXT_OUT)) u_chk (
  .sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .wb_cyc_in(wb_cyc_in),
  .wb_stb_in(wb_stb_in), .wb_ack_out(wb_ack_out), .wb_dat_out(wb_dat_out),
  .trace_enable_out(trace_enable_out), .state_hold_out(state_hold_out),
  .trig_packet_out(trig_packet_out), .trig_ind_out(trig_ind_out),
  .dbg_req_out(dbg_req_out), .ext_out_out(ext_out_out));

// File: verif/extout_trigger_control_tb_top.sv
// Self-checking bench for the external output and trigger block.
`timescale 1ns/1ps
module extout_trigger_control_tb_top;
  localparam int NX = 4;
  logic sys_clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic wb_cyc_in = 1'b0;
  logic wb_stb_in = 1'b0;
  logic wb_we_in = 1'b0;
  logic [11:0] wb_adr_in = 12'h000;
  logic [3:0] wb_sel_in = 4'h0;
  logic [31:0] wb_dat_in = 32'h0000_0000;
  logic [31:0] wb_dat_out, rd;
  logic wb_ack_out, fifo_empty, trace_en, hold, trig_pkt, trig_ind, dbg, irq;
  logic [15:0] res = 16'h8000;
  logic [3:0] ext;
  logic [7:0] trig_cnt;
  logic [10:0] sel_v [4];
  logic [3:0] exp4;
  int err_total = 0;
  int comparisons = 0;
  int n;
  xtc_top #(.N_EXT_OUT(NX), .N_RES(16)) dut (.sys_clk_in(sys_clk_in),
    .rst_b_in(rst_b_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
    .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in),
    .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
    .event_res_in(res), .fifo_empty_in(fifo_empty),
    .trace_enable_out(trace_en), .state_hold_out(hold),
    .trig_packet_out(trig_pkt), .trig_ind_out(trig_ind),
    .dbg_req_out(dbg), .ext_out_out(ext), .irq_out(irq));
  xtc_trace_sink sink (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in),
    .trace_enable_in(trace_en), .trig_ind_in(trig_ind),
    .fifo_empty_out(fifo_empty), .trig_cnt_out(trig_cnt));
  // Free-running 50 MHz clock
  initial begin
    forever #10 sys_clk_in = ~sys_clk_in;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic cyc(input int c);
    repeat (c) @(posedge sys_clk_in);
  endtask : cyc
  // Classic cycle; ack is read before the edge's own updates land
  task automatic wb(input logic we, input logic [9:0] idx, input logic [31:0] d);
    int k;
    k = 0;
    wb_cyc_in <= 1'b1;
    wb_stb_in <= 1'b1;
    wb_we_in <= we;
    wb_adr_in <= {idx, 2'b00};
    wb_sel_in <= 4'hF;
    wb_dat_in <= d;
    @(posedge sys_clk_in);
    while (wb_ack_out !== 1'b1 && k < 40) begin
      @(posedge sys_clk_in);
      k++;
    end
    rd = wb_dat_out;
    if (k == 40) err_total++;
    wb_cyc_in <= 1'b0;
    wb_stb_in <= 1'b0;
    wb_we_in <= 1'b0;
    @(posedge sys_clk_in);
  endtask : wb
  // Waits for the trigger pulse; counts edges from the event change
  task automatic wait_trig();
    n = 0;
    while (trig_pkt !== 1'b1 && n < 20) begin
      @(posedge sys_clk_in);
      n++;
    end
  endtask : wait_trig
  // Expected outputs: selected bits, masked to the implemented count
  function automatic logic [31:0] exp_ext(input logic [15:0] r);
    return {28'h0, r[3:0] & (4'hF >> (4 - NX))};
  endfunction : exp_ext
  // Event per the select encoding: resources A, B and a combining code
  function automatic logic exp_evt(input logic [15:0] r, input logic [10:0] s);
    logic a;
    logic b;
    a = r[s[3:0]];
    b = r[s[7:4]];
    case (s[10:8])
      3'h0: return a;
      3'h1: return !a;
      3'h2: return a & b;
      3'h3: return !a & b;
      3'h4: return !a & !b;
      3'h5: return a | b;
      3'h6: return !a | b;
      default: return !(a | b);
    endcase
  endfunction : exp_evt
  task automatic finish_test();
    $display("Counts: comparisons=%0d mismatches=%0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : finish_test
  // Watchdog sized well beyond the expected run
  initial begin
    #80000;
    err_total++;
    finish_test();
  end
  initial begin
    void'($urandom(44644));
    cyc(12);
    rst_b_in <= 1'b1;
    cyc(1);
    check(ext, 0);
    wb(0, xtc_pkg::IDX_MAIN_CTRL, 0);
    check(rd, xtc_pkg::CTRL_RESET);
    wb(0, xtc_pkg::IDX_CONFIG, 0);
    check(rd[22:20], NX);
    wb(0, xtc_pkg::IDX_ID, 0);
    check(rd, xtc_pkg::ID_VALUE);
    wb(0, 10'h0C5, 0);
    check(rd, 0);
    wb(1, 10'h200, 32'hFFFF_FFFF);
    wb(0, 10'h200, 0);
    check(rd, 0);
    $display("test registers done");
    for (int i = 0; i < NX; i++) begin
      sel_v[i] = 11'($urandom());
      wb(1, xtc_pkg::IDX_EXT_EVT0 + 10'(i), 32'(sel_v[i]));
    end
    wb(0, xtc_pkg::IDX_EXT_EVT0, 0);
    check(rd, 32'(sel_v[0]));
    wb(1, xtc_pkg::IDX_TRIG_EVT, 32'h0000_000E);
    wb(1, xtc_pkg::IDX_IRQ_MASK, 1);
    wb(1, xtc_pkg::IDX_MAIN_CTRL, 32'h0000_000C);
    check({trace_en, hold}, 2'b10);
    repeat (8) begin
      res <= 16'h8000 | (16'($urandom()) & 16'h3FFF);
      cyc(5);
      exp4 = 4'h0;
      for (int i = 0; i < NX; i++) exp4[i] = exp_evt(res, sel_v[i]);
      check(ext, 32'(exp4));
    end
    $display("test outputs done");
    res <= 16'hC000;
    wait_trig();
    check(n, 4);
    check({trig_ind, dbg}, 2'b11);
    cyc(1);
    check(irq, 1);
    wb(0, xtc_pkg::IDX_STATUS, 0);
    check({rd[3], rd[0]}, 2'b01);
    res <= 16'h8000;
    cyc(3);
    res <= 16'hC000;
    cyc(8);
    check(trig_cnt, 1);
    wb(1, xtc_pkg::IDX_IRQ_STATUS, 1);
    check(irq, 0);
    $display("test first trigger done");
    wb(1, xtc_pkg::IDX_MAIN_CTRL, 32'h0000_000D);
    res <= 16'h800F;
    cyc(5);
    check(ext, 0);
    check({trace_en, hold}, 2'b01);
    n = 0;
    do begin
      wb(0, xtc_pkg::IDX_STATUS, 0);
      n++;
    end while (rd[1] !== 1'b1 && n < 20);
    check({rd[3], rd[1], rd[0]}, 3'b110);
    for (int i = 0; i < NX; i++) wb(1, xtc_pkg::IDX_EXT_EVT0 + 10'(i), i);
    wb(1, xtc_pkg::IDX_IRQ_MASK, 0);
    wb(1, xtc_pkg::IDX_IRQ_STATUS, 3);
    wb(1, xtc_pkg::IDX_MAIN_CTRL, 0);
    cyc(5);
    check(ext, exp_ext(16'h800F));
    res <= 16'hC00F;
    wait_trig();
    check(n, 4);
    check({trig_ind, dbg}, 2'b00);
    cyc(2);
    check(irq, 0);
    wb(1, xtc_pkg::IDX_IRQ_MASK, 1);
    check(irq, 1);
    wb(1, xtc_pkg::IDX_IRQ_STATUS, 1);
    check(irq, 0);
    $display("test re-arm done");
    finish_test();
  end
endmodule : extout_trigger_control_tb_top
